// ==== design/risc_alu_pkg.sv ====
package risc_alu_pkg;

  // Instruction word geometry; bit 0 of the printed layout is the MSB
  localparam int WORD_W      = 32;
  localparam int IDX_W       = 5;
  localparam int REG_COUNT   = 32;
  localparam int IMM_W       = 16;
  localparam int OPC_HI      = 31;
  localparam int OPC_LO      = 26;
  localparam int DST_HI      = 25;
  localparam int DST_LO      = 21;
  localparam int SRCA_HI     = 20;
  localparam int SRCA_LO     = 16;
  localparam int SRCB_HI     = 15;
  localparam int SRCB_LO     = 11;
  localparam int FUNC_HI     = 10;
  localparam int IMM_HI      = 15;
  localparam int SHAMT_HI    = 4;
  // Barrel selector bits inside the function field
  localparam int BARREL_LEFT_POS  = 10;
  localparam int BARREL_ARITH_POS = 9;

  // Carry flag: status bit 29 in MSB-first numbering
  localparam int CARRY_BIT_MSB0 = 29;
  localparam int CARRY_POS      = WORD_W - 1 - CARRY_BIT_MSB0;
  localparam logic [WORD_W-1:0] STATUS_RESET = 32'h0000_0000;

  // Major opcodes
  localparam logic [5:0] OPC_SUM_FAMILY_HI2 = 6'h00;
  localparam logic [5:0] OPC_PRODUCT_REG    = 6'h10;
  localparam logic [5:0] OPC_BARREL_REG     = 6'h11;
  localparam logic [5:0] OPC_PRODUCT_IMM    = 6'h18;
  localparam logic [5:0] OPC_BARREL_IMM     = 6'h19;
  localparam logic [5:0] OPC_OR             = 6'h20;
  localparam logic [5:0] OPC_AND            = 6'h21;
  localparam logic [5:0] OPC_XOR            = 6'h22;
  localparam logic [5:0] OPC_AND_WITH_INV   = 6'h23;
  localparam logic [5:0] OPC_ONE_BIT        = 6'h24;
  // Upper-half prefix opcode, value arbitrary
  localparam logic [5:0] OPC_PREFIX_DEFAULT = 6'h3e;

  // Function codes of the one-bit right shifts (low 16 bits of the word)
  localparam logic [IMM_W-1:0] FN_ONE_RIGHT_ARITH   = 16'h0001;
  localparam logic [IMM_W-1:0] FN_ONE_RIGHT_CARRY   = 16'h0021;
  localparam logic [IMM_W-1:0] FN_ONE_RIGHT_LOGICAL = 16'h0041;

  typedef enum logic [2:0] {
    SH_RIGHT_LOGICAL   = 3'b000,
    SH_RIGHT_ARITH     = 3'b001,
    SH_LEFT            = 3'b010,
    SH_ONE_ARITH       = 3'b100,
    SH_ONE_CARRY       = 3'b101,
    SH_ONE_LOGICAL     = 3'b110
  } shift_mode_t;

  typedef struct packed {
    logic              valid;
    logic [IDX_W-1:0]  idx;
    logic [WORD_W-1:0] data;
  } writeback_t;

endpackage

// ==== design/risc_shift_unit.sv ====
`timescale 1ns/100ps
module risc_shift_unit
  import risc_alu_pkg::*;
(
  input  wire logic [WORD_W-1:0]   i_value,
  input  wire logic [SHAMT_HI:0]   i_amount,
  input  wire shift_mode_t         i_mode,
  input  wire logic                i_carry,
  output logic      [WORD_W-1:0]   o_result,
  output logic                     o_carry
);

  always_comb begin
    o_result = i_value;
    o_carry  = i_carry;
    case (i_mode)
      SH_RIGHT_LOGICAL: begin
        o_result = i_value >> i_amount;
      end
      SH_RIGHT_ARITH: begin
        o_result = WORD_W'($signed(i_value) >>> i_amount);
      end
      SH_LEFT: begin
        o_result = i_value << i_amount;
      end
      SH_ONE_ARITH: begin
        o_result = {i_value[WORD_W-1], i_value[WORD_W-1:1]};
        o_carry  = i_value[0];
      end
      SH_ONE_CARRY: begin
        o_result = {i_carry, i_value[WORD_W-1:1]};
        o_carry  = i_value[0];
      end
      SH_ONE_LOGICAL: begin
        o_result = {1'b0, i_value[WORD_W-1:1]};
        o_carry  = i_value[0];
      end
      default: begin
        o_result = i_value;
        o_carry  = i_carry;
      end
    endcase
  end

endmodule

// ==== design/risc_alu_decode.sv ====
// Operation
// [RULE_01] Words are 32 bits, two formats; opcode in bits 0-5, bit 0 MSB.
// [RULE_02] Register format: destination 6-10, first source 11-15, second 16-20.
// [RULE_03] Immediate format: one source, one destination, 16-bit immediate in bits 16-31.
// [RULE_04] A prefix just before an immediate form supplies the upper immediate half.
// [RULE_05] Thirty-two 32-bit registers, each reachable through a 5-bit index.
// [RULE_06] Without prefix the 16-bit immediate is sign extended to 32 bits.
// [RULE_07] Reverse subtract writes second source plus inverted first plus one.
// [RULE_08] Reverse subtract with carry adds the status carry instead of one.
// [RULE_09] Sum forms add both operands, carry variants add the carry flag too.
// [RULE_10] Immediate reverse subtract uses the extended immediate as second operand.
// [RULE_11] Register barrel shift picks right logical, right arithmetic or left.
// [RULE_12] Immediate barrel shift uses same selectors, amount from low immediate bits.
// [RULE_13] Logical ops: OR, AND, XOR, and AND with inverted second source.
// [RULE_14] One-bit arithmetic right shift keeps sign, shifted-out bit into carry.
// [RULE_15] One-bit right shift through carry: old carry enters the top.
// [RULE_16] One-bit logical right shift fills zero, shifted-out bit into carry.
// [RULE_17] Multiply writes the low 32 bits of the product.
// [RULE_18] Sum and reverse forms update carry unless they hold it.
`timescale 1ns/100ps
module risc_alu_decode
  import risc_alu_pkg::*;
#(
  parameter int               DATA_W        = WORD_W,
  parameter int               NUM_REGS      = REG_COUNT,
  parameter logic [5:0]       PREFIX_OPCODE = OPC_PREFIX_DEFAULT
)
(
  input  wire logic                i_clk,
  input  wire logic                i_rst_n,
  input  wire logic                i_instr_valid,
  input  wire logic [WORD_W-1:0]   i_instr,
  output writeback_t               o_writeback,
  output logic      [WORD_W-1:0]   o_status,
  output logic                     o_carry,
  output logic                     o_prefix_pending,
  output logic                     o_unhandled
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  if (DATA_W != WORD_W) begin : g_chk_width
    $error("risc_alu_decode: only a 32-bit datapath is supported");
  end
  if (NUM_REGS != REG_COUNT) begin : g_chk_regs
    $error("risc_alu_decode: register file must hold 32 entries");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [REG_COUNT-1:0][WORD_W-1:0] gpr;
    logic [IMM_W-1:0]                 prefix_hi;
    logic                             prefix_live;
    logic [WORD_W-1:0]                status;
    writeback_t                       wb;
    logic                             unhandled;
  } core_state_t;

  core_state_t q;
  core_state_t d;

  ////////////////////////////////////////////////////////////////////////////
  // Field extraction

  logic [5:0]        opcode;
  logic [IDX_W-1:0]  dst_idx;
  logic [IDX_W-1:0]  srca_idx;
  logic [IDX_W-1:0]  srcb_idx;
  logic [FUNC_HI:0]  func;
  logic [IMM_W-1:0]  imm;
  logic              imm_form;

  assign opcode   = i_instr[OPC_HI:OPC_LO];                  // [RULE_01]
  assign dst_idx  = i_instr[DST_HI:DST_LO];                  // [RULE_02]
  assign srca_idx = i_instr[SRCA_HI:SRCA_LO];                // [RULE_02]
  assign srcb_idx = i_instr[SRCB_HI:SRCB_LO];                // [RULE_02]
  assign func     = i_instr[FUNC_HI:0];                      // [RULE_02]
  assign imm      = i_instr[IMM_HI:0];                       // [RULE_03]
  // Third opcode bit from the top marks the immediate format
  assign imm_form = opcode[3];                               // [RULE_01]

  ////////////////////////////////////////////////////////////////////////////
  // Operands

  logic [WORD_W-1:0] first_source_reg;
  logic [WORD_W-1:0] second_source_reg;
  logic [WORD_W-1:0] imm_full;
  logic [WORD_W-1:0] operand_b;
  logic              carry_now;

  assign first_source_reg  = q.gpr[srca_idx];                // [RULE_05]
  assign second_source_reg = q.gpr[srcb_idx];                // [RULE_05]
  assign carry_now         = q.status[CARRY_POS];            // [RULE_08]

  always_comb begin
    if (q.prefix_live) begin
      imm_full = {q.prefix_hi, imm};                         // [RULE_04]
    end else begin
      imm_full = {{(WORD_W-IMM_W){imm[IMM_W-1]}}, imm};      // [RULE_06]
    end
  end

  assign operand_b = imm_form ? imm_full : second_source_reg;  // [RULE_03]

  ////////////////////////////////////////////////////////////////////////////
  // Sum and reverse subtract

  logic              is_reverse;
  logic              use_carry;
  logic              hold_carry;
  logic [WORD_W-1:0] addend_a;
  logic              carry_in;
  logic [WORD_W:0]   sum_full;

  assign is_reverse = opcode[0];
  assign use_carry  = opcode[1];
  assign hold_carry = opcode[2];

  // Reverse forms invert the first source; "+1" enters as the carry in
  assign addend_a = is_reverse ? ~first_source_reg : first_source_reg;   // [RULE_07]
  always_comb begin
    if (use_carry) begin
      carry_in = carry_now;                                  // [RULE_08] [RULE_09]
    end else begin
      carry_in = is_reverse;                                 // [RULE_07] [RULE_10]
    end
  end

  assign sum_full = {1'b0, operand_b} + {1'b0, addend_a}
                  + {{WORD_W{1'b0}}, carry_in};              // [RULE_09] [RULE_10]

  ////////////////////////////////////////////////////////////////////////////
  // Multiply

  logic [2*WORD_W-1:0] product_full;
  logic [WORD_W-1:0]   product_low;

  assign product_full = first_source_reg * operand_b;
  assign product_low  = product_full[WORD_W-1:0];            // [RULE_17]

  ////////////////////////////////////////////////////////////////////////////
  // Shifts

  shift_mode_t       shift_mode;
  logic [SHAMT_HI:0] shift_amount;
  logic [WORD_W-1:0] shift_result;
  logic              shift_carry;
  logic              barrel_ok;

  always_comb begin
    shift_mode   = SH_RIGHT_LOGICAL;
    shift_amount = imm_form ? imm[SHAMT_HI:0]
                            : second_source_reg[SHAMT_HI:0]; // [RULE_11] [RULE_12]
    barrel_ok    = 1'b0;
    if (opcode == OPC_ONE_BIT) begin
      shift_amount = 5'h01;
      if (imm == FN_ONE_RIGHT_ARITH) begin
        shift_mode = SH_ONE_ARITH;                           // [RULE_14]
      end else if (imm == FN_ONE_RIGHT_CARRY) begin
        shift_mode = SH_ONE_CARRY;                           // [RULE_15]
      end else begin
        shift_mode = SH_ONE_LOGICAL;                         // [RULE_16]
      end
    end else begin
      // Both selector bits set is not a defined shift
      if (func[BARREL_LEFT_POS] && !func[BARREL_ARITH_POS]) begin
        shift_mode = SH_LEFT;                                // [RULE_11] [RULE_12]
      end else if (func[BARREL_ARITH_POS] && !func[BARREL_LEFT_POS]) begin
        shift_mode = SH_RIGHT_ARITH;                         // [RULE_11] [RULE_12]
      end else begin
        shift_mode = SH_RIGHT_LOGICAL;                       // [RULE_11] [RULE_12]
      end
      if (imm_form) begin
        barrel_ok = (imm[IMM_HI:BARREL_LEFT_POS+1] == 5'h00)
                  && (imm[BARREL_ARITH_POS-1:SHAMT_HI+1] == 4'h0)
                  && !(func[BARREL_LEFT_POS] && func[BARREL_ARITH_POS]);
      end else begin
        barrel_ok = (func[BARREL_ARITH_POS-1:0] == 9'h000)
                  && !(func[BARREL_LEFT_POS] && func[BARREL_ARITH_POS]);
      end
    end
  end

  risc_shift_unit u_shift (
    .i_value  (first_source_reg),
    .i_amount (shift_amount),
    .i_mode   (shift_mode),
    .i_carry  (carry_now),
    .o_result (shift_result),
    .o_carry  (shift_carry)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decode and execute

  logic              do_write;
  logic [WORD_W-1:0] result;
  logic              carry_update;
  logic              carry_next;
  logic              bad_op;
  logic              is_prefix;

  always_comb begin
    do_write     = 1'b0;
    result       = '0;
    carry_update = 1'b0;
    carry_next   = carry_now;
    bad_op       = 1'b0;
    is_prefix    = 1'b0;
    if (opcode == PREFIX_OPCODE) begin
      is_prefix = 1'b1;                                      // [RULE_04]
    end else if (opcode[5:4] == OPC_SUM_FAMILY_HI2[5:4]) begin
      do_write     = 1'b1;
      result       = sum_full[WORD_W-1:0];                   // [RULE_07] [RULE_09]
      carry_update = !hold_carry;                            // [RULE_18]
      carry_next   = sum_full[WORD_W];                       // [RULE_18]
    end else if (opcode == OPC_PRODUCT_REG) begin
      do_write = (func == 11'h000);
      result   = product_low;                                // [RULE_17]
      bad_op   = (func != 11'h000);
    end else if (opcode == OPC_PRODUCT_IMM) begin
      do_write = 1'b1;
      result   = product_low;                                // [RULE_17]
    end else if (opcode == OPC_BARREL_REG || opcode == OPC_BARREL_IMM) begin
      do_write = barrel_ok;
      result   = shift_result;                               // [RULE_11] [RULE_12]
      bad_op   = !barrel_ok;
    end else if (opcode == OPC_OR) begin
      do_write = 1'b1;
      result   = first_source_reg | second_source_reg;       // [RULE_13]
    end else if (opcode == OPC_AND) begin
      do_write = 1'b1;
      result   = first_source_reg & second_source_reg;       // [RULE_13]
    end else if (opcode == OPC_XOR) begin
      do_write = 1'b1;
      result   = first_source_reg ^ second_source_reg;       // [RULE_13]
    end else if (opcode == OPC_AND_WITH_INV) begin
      do_write = 1'b1;
      result   = first_source_reg & ~second_source_reg;      // [RULE_13]
    end else if (opcode == OPC_ONE_BIT &&
                 (imm == FN_ONE_RIGHT_ARITH || imm == FN_ONE_RIGHT_CARRY ||
                  imm == FN_ONE_RIGHT_LOGICAL)) begin
      do_write     = 1'b1;
      result       = shift_result;                           // [RULE_14] [RULE_15] [RULE_16]
      carry_update = 1'b1;
      carry_next   = shift_carry;                            // [RULE_14] [RULE_15] [RULE_16]
    end else begin
      bad_op = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d              = q;
    d.wb.valid     = 1'b0;
    d.unhandled    = 1'b0;
    if (i_instr_valid) begin
      // A prefix lives for exactly the next instruction
      d.prefix_live = is_prefix;                             // [RULE_04]
      if (is_prefix) begin
        d.prefix_hi = imm;                                   // [RULE_04]
      end
      if (do_write) begin
        d.gpr[dst_idx] = result;                             // [RULE_05]
        d.wb.valid     = 1'b1;
        d.wb.idx       = dst_idx;
        d.wb.data      = result;
      end
      if (carry_update) begin
        d.status[CARRY_POS] = carry_next;                    // [RULE_18]
      end
      d.unhandled = bad_op;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q.gpr         <= '0;
      q.prefix_hi   <= 16'h0000;
      q.prefix_live <= 1'b0;
      q.status      <= STATUS_RESET;
      q.wb          <= '0;
      q.unhandled   <= 1'b0;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign o_writeback      = q.wb;
  assign o_status         = q.status;
  assign o_carry          = q.status[CARRY_POS];
  assign o_prefix_pending = q.prefix_live;
  assign o_unhandled      = q.unhandled;

endmodule

// ==== tb/risc_alu_decode_assertions.sv ====
`timescale 1ns/100ps
module risc_alu_decode_assertions
  import risc_alu_pkg::*;
#(
  parameter int         DATA_W        = WORD_W,
  parameter int         NUM_REGS      = REG_COUNT,
  parameter logic [5:0] PREFIX_OPCODE = OPC_PREFIX_DEFAULT
)
(
  input wire logic              i_clk,
  input wire logic              i_rst_n,
  input wire logic              i_instr_valid,
  input wire logic [WORD_W-1:0] i_instr,
  input wire writeback_t        o_writeback,
  input wire logic [WORD_W-1:0] o_status,
  input wire logic              o_carry,
  input wire logic              o_prefix_pending,
  input wire logic              o_unhandled
);
  logic [5:0] op;
  logic       go;
  assign op = i_instr[OPC_HI:OPC_LO];
  assign go = i_instr_valid;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_wb_from_issue: assert property (o_writeback.valid |-> $past(i_instr_valid))
    else $error("writeback without an issued word");
  a_wb_dest_idx: assert property (o_writeback.valid |-> o_writeback.idx == $past(i_instr[DST_HI:DST_LO]))
    else $error("writeback index is not the destination field");
  a_refuse_quiet: assert property (o_unhandled |-> !o_writeback.valid && $stable(o_carry))
    else $error("refused word changed state");
  a_carry_status: assert property (o_carry == o_status[CARRY_POS])
    else $error("carry output differs from status bit");
  a_hold_keeps_carry: assert property (go && (op[5:4] == 2'b00 && op[2] || op[5:2] == 4'b1000) |=> $stable(o_carry))
    else $error("carry moved on a holding form");
  a_prefix_sets: assert property (go && op == PREFIX_OPCODE |=> o_prefix_pending && !o_writeback.valid)
    else $error("prefix not held");
  a_prefix_clears: assert property (go && op != PREFIX_OPCODE |=> !o_prefix_pending)
    else $error("prefix not consumed");
  a_left_zero_fill: assert property (go && op == OPC_BARREL_IMM && i_instr[15:5] == 11'h020 |=>
      o_writeback.valid && (o_writeback.data & ((32'h1 << $past(i_instr[4:0])) - 32'h1)) == 32'h0)
    else $error("left shift low bits not zero");
  a_one_logical: assert property (go && op == OPC_ONE_BIT && i_instr[15:0] == FN_ONE_RIGHT_LOGICAL |=>
      o_writeback.valid && !o_writeback.data[31])
    else $error("logical one-bit shift top bit set");
  a_one_arith: assert property (go && op == OPC_ONE_BIT && i_instr[15:0] == FN_ONE_RIGHT_ARITH |=>
      o_writeback.valid && o_writeback.data[31] == o_writeback.data[30])
    else $error("arithmetic one-bit shift lost sign");
  a_one_carry: assert property (go && op == OPC_ONE_BIT && i_instr[15:0] == FN_ONE_RIGHT_CARRY |=>
      o_writeback.valid && o_writeback.data[31] == $past(o_carry))
    else $error("carry not shifted into top bit");

  c_prefix_use: cover property (go && op == PREFIX_OPCODE ##1 go && op == 6'h0c);
  c_refused: cover property (o_unhandled);
  c_carry_rise: cover property ($rose(o_carry));
endmodule

bind risc_alu_decode risc_alu_decode_assertions #(.DATA_W(DATA_W), .NUM_REGS(NUM_REGS),
  .PREFIX_OPCODE(PREFIX_OPCODE)) risc_alu_decode_assertions_i (.i_clk, .i_rst_n, .i_instr_valid,
  .i_instr, .o_writeback, .o_status, .o_carry, .o_prefix_pending, .o_unhandled);

// ==== tb/fetch_stage_model.sv ====
`timescale 1ns/100ps
module fetch_stage_model
  import risc_alu_pkg::*;
(
  input  wire logic              i_clk,
  output logic                   o_valid,
  output logic      [WORD_W-1:0] o_instr
);
  initial begin
    o_valid = 1'b0;
    o_instr = '0;
  end
  // Offers one word for exactly one taking edge
  task automatic issue(input logic [WORD_W-1:0] w);
    o_valid = 1'b1;
    o_instr = w;
    @(posedge i_clk);
    #1;
  endtask
  // Released word lines do not keep the last value
  task automatic idle();
    o_valid = 1'b0;
    o_instr = ~o_instr;
    @(posedge i_clk);
    #1;
  endtask
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/100ps
module tb;
  import risc_alu_pkg::*;
  logic              i_clk;
  logic              i_rst_n;
  wire logic         i_instr_valid;
  wire [WORD_W-1:0]  i_instr;
  writeback_t        o_writeback;
  logic [WORD_W-1:0] o_status;
  logic              o_carry;
  logic              o_prefix_pending;
  logic              o_unhandled;
  logic [WORD_W-1:0] gpr [REG_COUNT];
  logic              c;
  logic              pre;
  logic [IMM_W-1:0]  hi;
  logic [5:0]        ops [10] = '{6'h10, 6'h11, 6'h18, 6'h19, 6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h3e};
  int                fails;
  int                checks;
  int                seed;

  risc_alu_decode risc_alu_decode_i (.i_clk, .i_rst_n, .i_instr_valid, .i_instr, .o_writeback,
    .o_status, .o_carry, .o_prefix_pending, .o_unhandled);
  fetch_stage_model fetch_stage_model_i (.i_clk, .o_valid(i_instr_valid), .o_instr(i_instr));

  initial i_clk = 1'b0;
  always #2 i_clk = ~i_clk;

  //////////////////////////////////////////////////////////////
  task automatic chk(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic clear_model();
    foreach (gpr[k]) gpr[k] = '0;
    c = 1'b0;
    pre = 1'b0;
  endtask

  // Issues one word and compares the answer one edge later against the model
  task automatic run(input logic [WORD_W-1:0] w);
    logic [5:0]        op;
    logic [WORD_W-1:0] a, b, m, r;
    logic [4:0]        n;
    logic              wr, unh, co, pf;
    op = w[31:26];
    a = gpr[w[20:16]];
    b = gpr[w[15:11]];
    m = pre ? {hi, w[15:0]} : {{16{w[15]}}, w[15:0]};
    n = op[3] ? w[4:0] : b[4:0];
    pf = (op == OPC_PREFIX_DEFAULT);
    wr = !pf;
    unh = 1'b0;
    co = c;
    r = '0;
    if (pf) begin
      hi = w[15:0];
    end else if (op[5:4] == 2'b00) begin
      {co, r} = {1'b0, op[0] ? ~a : a} + {1'b0, op[3] ? m : b} + (op[1] ? c : op[0]);
      if (op[2]) co = c;
    end else if (op == OPC_PRODUCT_IMM || op == OPC_PRODUCT_REG && w[10:0] == 11'h0) begin
      r = a * (op[3] ? m : b);
    end else if ((op == OPC_BARREL_REG || op == OPC_BARREL_IMM) && w[10:9] != 2'b11
        && (op[3] ? w[15:11] == 5'h0 && w[8:5] == 4'h0 : w[8:0] == 9'h0)) begin
      if (w[10]) r = a << n;
      else if (w[9]) r = $unsigned($signed(a) >>> n);
      else r = a >> n;
    end else if (op[5:2] == 4'b1000) begin
      r = op[1] ? (op[0] ? a & ~b : a ^ b) : (op[0] ? a & b : a | b);
    end else if (op == OPC_ONE_BIT && (w[15:0] == FN_ONE_RIGHT_ARITH || w[15:0] == FN_ONE_RIGHT_CARRY
        || w[15:0] == FN_ONE_RIGHT_LOGICAL)) begin
      r = {w[5] ? c : w[6] ? 1'b0 : a[31], a[31:1]};
      co = a[0];
    end else begin
      wr = 1'b0;
      unh = 1'b1;
    end
    pre = pf;
    fetch_stage_model_i.issue(w);
    chk({o_writeback.valid, o_unhandled, o_carry, o_prefix_pending}, {wr, unh, co, pf});
    chk(o_status, {29'h0, co, 2'h0});
    if (wr) chk(o_writeback.data, r);
    if (wr) chk({27'h0, o_writeback.idx}, {27'h0, w[25:21]});
    if (wr) gpr[w[25:21]] = r;
    c = co;
  endtask

  task automatic pause();
    fetch_stage_model_i.idle();
    chk({o_writeback.valid, o_unhandled, o_prefix_pending}, {2'b00, pre});
  endtask

  function automatic logic [WORD_W-1:0] rnd_word();
    logic [WORD_W-1:0] w, x;
    logic [1:0]        s;
    x = $random(seed);
    w = $random(seed);
    s = (x[1:0] == 2'b11) ? 2'b00 : x[1:0];
    w[31:26] = (x[7:3] < 5'd16) ? {1'b0, x[7:3]} : ops[x[7:3] % 5'd10];
    if (!w[29] || w[31]) w[10:0] = 11'h0;
    if (w[31:26] == OPC_BARREL_REG) w[10:9] = s;
    if (w[31:26] == OPC_BARREL_IMM) w[15:5] = {5'h0, s, 4'h0};
    if (w[31:26] == OPC_ONE_BIT) w[15:0] = s[1] ? FN_ONE_RIGHT_LOGICAL : s[0] ? FN_ONE_RIGHT_CARRY : FN_ONE_RIGHT_ARITH;
    return w;
  endfunction

  task automatic wrap_up();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////
  initial begin
    #40000;
    fails++;
    wrap_up();
  end

  initial begin
    seed = 32'hc689;
    i_rst_n = 1'b0;
    clear_model();
    repeat (8) @(posedge i_clk);
    #1;
    i_rst_n = 1'b1;
    run({OPC_PREFIX_DEFAULT, 10'h0, 16'h8000});
    pause();
    run({6'h0c, 5'd1, 5'd0, 16'h0001});
    run({6'h08, 5'd2, 5'd0, 16'hffff});
    run({6'h26, 5'd3, 5'd1, 16'h0000});
    run({OPC_PRODUCT_REG, 5'd3, 5'd1, 5'd2, 11'h001});
    run({OPC_BARREL_REG, 5'd3, 5'd1, 5'd2, 11'h600});
    for (int k = 0; k < 16; k++) run({k[5:0], 5'd4, 5'd1, 5'd2, 11'h0});
    $display("corner test done");
    for (int k = 0; k < 3000; k++) begin
      run(rnd_word());
      if (k % 13 == 0) pause();
    end
    $display("random test done");
    i_rst_n = 1'b0;
    #1;
    chk({o_writeback.valid, o_unhandled, o_carry, o_prefix_pending}, '0);
    chk(o_status, STATUS_RESET);
    clear_model();
    fetch_stage_model_i.idle();
    fetch_stage_model_i.idle();
    i_rst_n = 1'b1;
    for (int k = 0; k < 300; k++) run(rnd_word());
    $display("reset test done");
    wrap_up();
  end
endmodule
